// ---- rtl/pixel_key_out.sv ----
// Pixel output stage: color keying, border, horizontal zoom, signature and
// sense test register behind the indexed register port.
// Assumes a 200 MHz clock_in, pins sampled here, and a same-clock DAC sink.
`timescale 1ns/100ps
`default_nettype none
`include "pixel_key_params.svh"

// What this block does
// - Key is AND of enabled compares, XNOR polarity
// - Color compare is inclusive low-high range
// - Key one shows palette, zero shows direct
// - Enables and polarity reset to zero
// - Overlay masked, right-aligned, page fills top
// - Narrow direct color left-aligned, zero filled
// - Palette bypass OR key selects palette
// - Eight range registers then key control
// - Border color when border enabled and high during blank
// - Pedestal only during blank, unless border enabled and high
// - Border input sampled on latch clock
// - Each pixel repeated zoom factor dot clocks
// - Zoom never applied to VGA port data
// - Packed 24-bit modes zoom at most 8x
// - Signature updates on two hsyncs in blank
// - Signature accumulates only outside blanking
// - Bit select 0-23 picks DAC line
// - Signature readable as low and high byte
// - Sense low when any output above threshold
// - Sense register: disable, zeros, R G B
// - Disable bit stops sensing, clear at reset
// - Sense latched on sampled blank falling edge
module pixel_key_out
   import pixel_key_pkg::*;
#(
   parameter int DIRECT_BITS  = 8,
   parameter int OVERLAY_BITS = 8,
   parameter int DOT_DIV      = 2
) (
   input  wire logic        clock_in,
   input  wire logic        sys_rst_in,
   input  wire logic [7:0]  reg_index_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_wr_in,
   input  wire logic        reg_rd_in,
   output var  logic [7:0]  reg_rdata_out,
   input  wire logic        latch_clock_in,
   input  wire logic        system_blank_n_in,
   input  wire logic        border_input_in,
   input  wire logic        hsync_n_in,
   input  wire logic [7:0]  direct_red_in,
   input  wire logic [7:0]  direct_green_in,
   input  wire logic [7:0]  direct_blue_in,
   input  wire logic [7:0]  overlay_in,
   input  wire logic [23:0] palette_rgb_in,
   input  wire logic [2:0]  sense_cmp_in,
   input  wire logic        palette_bypass_in,
   input  wire logic        border_enable_in,
   input  wire logic        vga_port_select_in,
   input  wire logic        packed24_mode_in,
   input  wire logic [7:0]  read_mask_in,
   input  wire logic [7:0]  palette_page_in,
   input  wire logic [23:0] border_rgb_in,
   input  wire logic        dac_ready_in,
   output var  logic [23:0] dac_rgb_out,
   output var  logic        dac_valid_out,
   output var  logic        pedestal_out,
   output var  logic        pixel_ready_out,
   output var  logic        sense_n_out
);

   // ******************************
   // Pin synchronisers
   // ******************************
   localparam int SW = 63;
   // Reset to idle pin levels (blank and sync high) so release makes no false edge
   localparam logic [SW-1:0] SYNC_IDLE = {4'b0101, 59'h0};
   logic [SW-1:0] pin_raw;
   logic [SW-1:0] sync1_q;
   logic [SW-1:0] sync2_q;

   assign pin_raw = {latch_clock_in, system_blank_n_in, border_input_in, hsync_n_in, sense_cmp_in,
                     direct_red_in, direct_green_in, direct_blue_in, overlay_in, palette_rgb_in};

   genvar gi;
   generate
      for (gi = 0; gi < SW; gi++) begin : g_sync
         always_ff @(posedge clock_in) begin
            if (sys_rst_in) begin
               sync1_q[gi] <= SYNC_IDLE[gi];
               sync2_q[gi] <= SYNC_IDLE[gi];
            end else begin
               sync1_q[gi] <= pin_raw[gi];
               sync2_q[gi] <= sync1_q[gi];
            end
         end
      end
   endgenerate

   logic        latch_clock_s;
   logic        blank_n_s;
   logic        border_s;
   logic        hsync_n_s;
   logic [2:0]  sense_s;
   logic [7:0]  red_s;
   logic [7:0]  green_s;
   logic [7:0]  blue_s;
   logic [7:0]  ovl_s;
   logic [23:0] pal_s;

   assign {latch_clock_s, blank_n_s, border_s, hsync_n_s, sense_s, red_s, green_s, blue_s, ovl_s, pal_s} = sync2_q;

   // ******************************
   // State
   // ******************************
   localparam int DW = $clog2(DOT_DIV + 1);

   logic [7:0]  range_q [8];
   logic [7:0]  range_d [8];
   logic [7:0]  key_ctrl_q,   key_ctrl_d;
   logic        sense_dis_q,  sense_dis_d;
   logic [4:0]  sig_sel_q,    sig_sel_d;
   logic [7:0]  rdata_q,      rdata_d;
   logic        latch_clock_prev_q,  latch_clock_prev_d;
   logic        hs_prev_q,    hs_prev_d;
   logic        blank_lat_q,  blank_lat_d;
   logic [DW-1:0] dot_cnt_q,  dot_cnt_d;
   pix_s        fifo_q [2];
   pix_s        fifo_d [2];
   logic [1:0]  fifo_cnt_q,   fifo_cnt_d;
   logic        prdy_q,       prdy_d;
   logic [23:0] dac_q,        dac_d;
   logic        dval_q,       dval_d;
   logic        dblank_q,     dblank_d;
   logic        ped_q,        ped_d;
   logic [4:0]  rep_q,        rep_d;
   logic [15:0] crc_q,        crc_d;
   logic [15:0] sig_q,        sig_d;
   logic        hs_cnt_q,     hs_cnt_d;
   logic [2:0]  sense_lat_q,  sense_lat_d;
   logic        sense_n_q,    sense_n_d;

   // ******************************
   // Pixel path helpers
   // ******************************
   function automatic logic in_range(input logic [7:0] lo, input logic [7:0] hi, input logic [7:0] v);
      in_range = (lo <= v) && (v <= hi);
   endfunction

   localparam logic [7:0] OVL_MASK = 8'(({8'h0, 8'hff} >> (8 - OVERLAY_BITS)));

   pix_s        head;
   logic [7:0]  ovl_cmp;
   logic [7:0]  red_al;
   logic [7:0]  green_al;
   logic [7:0]  blue_al;
   logic [3:0]  hit;
   logic        key_val;
   logic        pal_sel;
   logic [23:0] color;
   logic [2:0]  zcode;
   logic [4:0]  zrep;
   logic        latch_edge;
   logic        dot_tick;
   logic        push;
   logic        pop;
   logic        xfer;
   logic        crc_fb;
   logic [7:0]  sig_line;

   always_comb begin
      head     = fifo_q[0];
      ovl_cmp  = (head.overlay & read_mask_in & OVL_MASK) | (palette_page_in & ~OVL_MASK);
      red_al   = 8'(head.red   << (8 - DIRECT_BITS));
      green_al = 8'(head.green << (8 - DIRECT_BITS));
      blue_al  = 8'(head.blue  << (8 - DIRECT_BITS));
      hit[0]   = in_range(range_q[0], range_q[1], ovl_cmp);
      hit[1]   = in_range(range_q[2], range_q[3], red_al);
      hit[2]   = in_range(range_q[4], range_q[5], green_al);
      hit[3]   = in_range(range_q[6], range_q[7], blue_al);
      key_val  = (&(hit | ~key_ctrl_q[`KEY_EN_MSB:`KEY_EN_LSB])) ^ ~key_ctrl_q[`KEY_POL_BIT];
      pal_sel  = palette_bypass_in | key_val;
      if (head.blank_act) begin
         color = (border_enable_in && head.border) ? border_rgb_in : 24'h000000;
      end else if (pal_sel) begin
         color = head.palette;
      end else begin
         color = {red_al, green_al, blue_al};
      end
      // Unused codes fall back to 1x rather than a surprise factor
      zcode = key_ctrl_q[`ZOOM_MSB:`ZOOM_LSB];
      if (zcode > `ZOOM_TOP_CODE) begin
         zcode = ZOOM_X1;
      end
      if (packed24_mode_in && (zcode > `ZOOM_PACKED_MAX)) begin
         zcode = `ZOOM_PACKED_MAX;
      end
      zrep = vga_port_select_in ? 5'h00 : 5'((6'h01 << zcode) - 6'h01);
   end

   // ******************************
   // Next-state logic
   // ******************************
   always_comb begin
      range_d     = range_q;
      key_ctrl_d  = key_ctrl_q;
      sense_dis_d = sense_dis_q;
      sig_sel_d   = sig_sel_q;
      rdata_d     = rdata_q;
      latch_clock_prev_d = latch_clock_s;
      hs_prev_d   = hsync_n_s;
      blank_lat_d = blank_lat_q;
      fifo_d      = fifo_q;
      fifo_cnt_d  = fifo_cnt_q;
      dac_d       = dac_q;
      dval_d      = dval_q;
      dblank_d    = dblank_q;
      ped_d       = ped_q;
      rep_d       = rep_q;
      crc_d       = crc_q;
      sig_d       = sig_q;
      hs_cnt_d    = hs_cnt_q;
      sense_lat_d = sense_lat_q;
      sense_n_d   = sense_n_q;

      // Register port
      if (reg_wr_in) begin
         if (reg_index_in >= `IDX_RANGE_FIRST && reg_index_in <= `IDX_RANGE_LAST) begin
            range_d[reg_index_in[2:0]] = reg_wdata_in;
         end else if (reg_index_in == `IDX_KEY_CTRL) begin
            key_ctrl_d = reg_wdata_in;
         end else if (reg_index_in == `IDX_SENSE_TEST) begin
            sense_dis_d = reg_wdata_in[`SENSE_DIS_BIT];
         end else if (reg_index_in == `IDX_SIG_SELECT) begin
            // Out-of-range selects are refused; the old line stays chosen
            if (reg_wdata_in[4:0] <= `SIG_SELECT_MAX && reg_wdata_in[7:5] == 3'h0) begin
               sig_sel_d = reg_wdata_in[4:0];
            end
         end
      end
      if (reg_rd_in) begin
         if (reg_index_in >= `IDX_RANGE_FIRST && reg_index_in <= `IDX_RANGE_LAST) begin
            rdata_d = range_q[reg_index_in[2:0]];
         end else if (reg_index_in == `IDX_KEY_CTRL) begin
            rdata_d = key_ctrl_q;
         end else if (reg_index_in == `IDX_SENSE_TEST) begin
            rdata_d = {sense_dis_q, 4'h0, sense_lat_q};
         end else if (reg_index_in == `IDX_SIG_LOW) begin
            rdata_d = sig_q[7:0];
         end else if (reg_index_in == `IDX_SIG_HIGH) begin
            rdata_d = sig_q[15:8];
         end else if (reg_index_in == `IDX_SIG_SELECT) begin
            rdata_d = {3'h0, sig_sel_q};
         end else begin
            rdata_d = 8'h00;
         end
      end

      // Latch clock edges load pixels; a full buffer holds pixel_ready low
      latch_edge = latch_clock_s & ~latch_clock_prev_q;
      push       = latch_edge && (fifo_cnt_q != 2'h2);
      if (latch_edge) begin
         blank_lat_d = ~blank_n_s;
         if (~blank_n_s && !blank_lat_q) begin
            sense_lat_d = sense_dis_q ? 3'h0 : sense_s;
            sense_n_d   = sense_dis_q | ~(|sense_s);
         end
      end

      // Dot clock: repeat, then pop; a stalled sink freezes the stage
      dot_tick = (dot_cnt_q == DW'(DOT_DIV - 1));
      dot_cnt_d = dot_tick ? '0 : DW'(dot_cnt_q + 1'b1);
      xfer = dval_q && dac_ready_in;
      pop  = 1'b0;
      if (dot_tick && (!dval_q || dac_ready_in)) begin
         // Valid drops between ticks once a dot is taken, so count on rep alone
         if (rep_q != 5'h00) begin
            rep_d  = 5'(rep_q - 5'h01);
            dval_d = 1'b1;
         end else if (fifo_cnt_q != 2'h0) begin
            pop      = 1'b1;
            dac_d    = color;
            dblank_d = head.blank_act;
            ped_d    = head.blank_act && !(border_enable_in && head.border);
            rep_d    = zrep;
            dval_d   = 1'b1;
         end else begin
            dval_d = 1'b0;
         end
      end else if (xfer) begin
         dval_d = 1'b0;
      end

      if (pop) begin
         fifo_d[0] = fifo_q[1];
      end
      if (push) begin
         fifo_d[(pop ? fifo_cnt_q - 2'h1 : fifo_cnt_q) == 2'h0 ? 0 : 1] =
            '{blank_act: ~blank_n_s, border: border_s, red: red_s, green: green_s,
              blue: blue_s, overlay: ovl_s, palette: pal_s};
      end
      fifo_cnt_d = 2'(fifo_cnt_q + {1'b0, push} - {1'b0, pop});
      prdy_d     = (fifo_cnt_d != 2'h2);

      // Signature over each delivered active dot
      // Select counts from red, which sits in the top byte of the DAC word
      sig_line = sig_sel_q[4] ? dac_q[7:0] : (sig_sel_q[3] ? dac_q[15:8] : dac_q[23:16]);
      crc_fb   = sig_line[sig_sel_q[2:0]] ^ crc_q[15];
      if (xfer && !dblank_q) begin
         crc_d = {crc_q[14:0], 1'b0} ^ (crc_fb ? `SIG_POLY : 16'h0000);
      end
      if (!blank_lat_q) begin
         hs_cnt_d = 1'b0;
      end else if (hs_prev_q && !hsync_n_s) begin
         if (hs_cnt_q) begin
            sig_d    = crc_q;
            crc_d    = `SIG_SEED;
            hs_cnt_d = 1'b0;
         end else begin
            hs_cnt_d = 1'b1;
         end
      end
   end

   // ******************************
   // Registers
   // ******************************
   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         for (int i = 0; i < 8; i++) begin
            range_q[i] <= `RANGE_RESET;
         end
         key_ctrl_q  <= `KEY_CTRL_RESET;
         sense_dis_q <= 1'b0;
         sig_sel_q   <= `SIG_SELECT_RESET;
         rdata_q     <= 8'h00;
         latch_clock_prev_q <= 1'b0;
         hs_prev_q   <= 1'b1;
         blank_lat_q <= 1'b0;
         dot_cnt_q   <= '0;
         fifo_q[0]   <= '0;
         fifo_q[1]   <= '0;
         fifo_cnt_q  <= 2'h0;
         prdy_q      <= 1'b0;
         dac_q       <= 24'h000000;
         dval_q      <= 1'b0;
         dblank_q    <= 1'b0;
         ped_q       <= 1'b0;
         rep_q       <= 5'h00;
         crc_q       <= `SIG_SEED;
         sig_q       <= 16'h0000;
         hs_cnt_q    <= 1'b0;
         sense_lat_q <= 3'h0;
         sense_n_q   <= 1'b1;
      end else begin
         range_q     <= range_d;
         key_ctrl_q  <= key_ctrl_d;
         sense_dis_q <= sense_dis_d;
         sig_sel_q   <= sig_sel_d;
         rdata_q     <= rdata_d;
         latch_clock_prev_q <= latch_clock_prev_d;
         hs_prev_q   <= hs_prev_d;
         blank_lat_q <= blank_lat_d;
         dot_cnt_q   <= dot_cnt_d;
         fifo_q      <= fifo_d;
         fifo_cnt_q  <= fifo_cnt_d;
         prdy_q      <= prdy_d;
         dac_q       <= dac_d;
         dval_q      <= dval_d;
         dblank_q    <= dblank_d;
         ped_q       <= ped_d;
         rep_q       <= rep_d;
         crc_q       <= crc_d;
         sig_q       <= sig_d;
         hs_cnt_q    <= hs_cnt_d;
         sense_lat_q <= sense_lat_d;
         sense_n_q   <= sense_n_d;
      end
   end

   assign reg_rdata_out   = rdata_q;
   assign dac_rgb_out     = dac_q;
   assign dac_valid_out   = dval_q;
   assign pedestal_out    = ped_q;
   assign pixel_ready_out = prdy_q;
   assign sense_n_out     = sense_n_q;

endmodule // pixel_key_out
`default_nettype wire

// ---- rtl/pixel_key_params.svh ----
// Constants for the pixel output stage: register indexes, reset values,
// signature settings and zoom limits.
// Assumes inclusion by bare name from the package and the design module.
`ifndef PIXEL_KEY_PARAMS_SVH
`define PIXEL_KEY_PARAMS_SVH

// ******************************
// Register indexes
// ******************************
`define IDX_RANGE_FIRST   8'h30
`define IDX_RANGE_LAST    8'h37
`define IDX_KEY_CTRL      8'h38
`define IDX_SENSE_TEST    8'h3a
`define IDX_SIG_LOW       8'h3c
`define IDX_SIG_HIGH      8'h3d
`define IDX_SIG_SELECT    8'h3e

// ******************************
// Field positions and reset values
// ******************************
`define KEY_EN_LSB        0
`define KEY_EN_MSB        3
`define KEY_POL_BIT       4
`define ZOOM_LSB          5
`define ZOOM_MSB          7
`define SENSE_DIS_BIT     7
`define KEY_CTRL_RESET    8'h00
`define RANGE_RESET       8'h00
`define SIG_SELECT_RESET  5'h00
`define SIG_SELECT_MAX    5'h17

// ******************************
// Signature shift register
// ******************************
`define SIG_POLY          16'h1021
`define SIG_SEED          16'hffff

// ******************************
// Zoom
// ******************************
`define ZOOM_PACKED_MAX   3'h3
`define ZOOM_TOP_CODE     3'h5

`endif

// ---- rtl/pixel_key_pkg.sv ----
// Types shared by the pixel output stage.
// Assumes the constants header sits beside it on the include path.
`include "pixel_key_params.svh"

package pixel_key_pkg;

   // Zoom field codes: replication of 2 to the code
   typedef enum logic [2:0] {
      ZOOM_X1  = 3'h0,
      ZOOM_X2  = 3'h1,
      ZOOM_X4  = 3'h2,
      ZOOM_X8  = 3'h3,
      ZOOM_X16 = 3'h4,
      ZOOM_X32 = 3'h5
   } zoom_e;

   // One pixel as latched from the controller
   typedef struct packed {
      logic        blank_act;
      logic        border;
      logic [7:0]  red;
      logic [7:0]  green;
      logic [7:0]  blue;
      logic [7:0]  overlay;
      logic [23:0] palette;
   } pix_s;

endpackage

// ---- dv/pixel_key_out_monitor.sv ----
// Concurrent checks on the ports of the pixel output stage.
// Assumes it is bound into pixel_key_out and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module pixel_key_out_monitor (
   input wire logic        clock_in,
   input wire logic        sys_rst_in,
   input wire logic [7:0]  reg_index_in,
   input wire logic [7:0]  reg_wdata_in,
   input wire logic        reg_wr_in,
   input wire logic        reg_rd_in,
   input wire logic [7:0]  reg_rdata_out,
   input wire logic        palette_bypass_in,
   input wire logic        border_enable_in,
   input wire logic [23:0] palette_rgb_in,
   input wire logic        dac_ready_in,
   input wire logic [23:0] dac_rgb_out,
   input wire logic        dac_valid_out,
   input wire logic        pedestal_out
);
   // ********
   // Checks
   // ********
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (sys_rst_in);
   a_unmapped_read_zero: assert property (reg_rd_in && reg_index_in == 8'h40 |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   a_ctrl_read_back: assert property (
      reg_wr_in && reg_index_in == 8'h38 ##1 reg_rd_in && reg_index_in == 8'h38
      |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("key control read back wrong");
   a_rdata_stands: assert property (!reg_rd_in |=> $stable(reg_rdata_out))
      else $error("read data moved without a read");
   a_sense_reserved_zero: assert property (reg_rd_in && reg_index_in == 8'h3a |=> reg_rdata_out[6:3] == 4'h0)
      else $error("sense reserved bits not zero");
   a_sense_disable_kept: assert property (
      reg_wr_in && reg_index_in == 8'h3a ##1 reg_rd_in && reg_index_in == 8'h3a
      |=> reg_rdata_out[7] == $past(reg_wdata_in[7], 2)) else $error("sense disable not stored");
   a_sig_select_max: assert property (reg_rd_in && reg_index_in == 8'h3e |=> reg_rdata_out <= 8'h17)
      else $error("line select out of range");
   a_sig_select_write: assert property (
      reg_wr_in && reg_index_in == 8'h3e && reg_wdata_in <= 8'h17 ##1 reg_rd_in && reg_index_in == 8'h3e
      |=> reg_rdata_out == $past(reg_wdata_in, 2)) else $error("line select not stored");
   a_stall_holds_pixel: assert property (dac_valid_out && !dac_ready_in |=> dac_valid_out && $stable(dac_rgb_out))
      else $error("pixel lost during stall");
   a_bypass_palette: assert property (
      dac_valid_out && !pedestal_out && !border_enable_in && palette_bypass_in && $past(palette_bypass_in, 40)
      && palette_rgb_in == $past(palette_rgb_in, 40) |-> dac_rgb_out == palette_rgb_in)
      else $error("bypass did not show palette");
endmodule // pixel_key_out_monitor
bind pixel_key_out pixel_key_out_monitor pixel_key_out_monitor_inst (.*);
`default_nettype wire

// ---- dv/pixel_ctrl_model.sv ----
// Graphics controller model: drives pixel fields, blank, border and sync.
// Assumes the bench sets the wanted pixel before each burst.
`timescale 1ns/100ps
`default_nettype none
module pixel_ctrl_model import pixel_key_pkg::*; (
   input  wire pix_s  want_in,
   output var  pix_s  pix_out,
   output var  logic  latch_clock_out,
   output var  logic  hsync_n_out
);
   // ********
   // Bursts
   // ********
   initial begin
      pix_out = '0;
      latch_clock_out = 1'b0;
      hsync_n_out = 1'b1;
   end
   // Clock stands still between bursts; fields change away from the rising edge
   // Period stretched by the zoom factor so the buffer never overflows
   // Border travels with the latch-clocked fields
   task automatic send(input int n, input int slow);
      for (int i = 0; i < n; i++) begin
         pix_out = want_in;
         #(32 * slow) latch_clock_out = 1'b1;
         #(32 * slow) latch_clock_out = 1'b0;
      end
   endtask
   // Two active-low sync pulses
   task automatic sync_pair();
      repeat (2) begin
         #100 hsync_n_out = 1'b0;
         #100 hsync_n_out = 1'b1;
      end
   endtask
endmodule // pixel_ctrl_model
`default_nettype wire

// ---- dv/pixel_key_out_tb.sv ----
// Self-checking bench for the pixel output stage.
// Assumes the controller model drives the pixel pins; registers by index port.
`timescale 1ns/100ps
`default_nettype none
`include "pixel_key_params.svh"
module pixel_key_out_tb import pixel_key_pkg::*; ;
   logic        clock_in = 1'b0, sys_rst_in = 1'b1, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic [7:0]  reg_index_in = 8'h00, reg_wdata_in = 8'h00, read_mask_in = 8'hff, reg_rdata_out;
   logic        palette_bypass_in = 1'b0, border_enable_in = 1'b0, vga_port_select_in = 1'b0;
   logic        packed24_mode_in = 1'b0, dac_ready_in = 1'b1, latch_clock, hsync_n;
   logic [2:0]  sense_cmp_in = 3'b000;
   logic [23:0] border_rgb_in = 24'h0a0b0c, dac_rgb_out;
   logic        dac_valid_out, pedestal_out, pixel_ready_out, sense_n_out;
   pix_s        want = '{1'b0, 1'b0, 8'h40, 8'h80, 8'hc0, 8'h5a, 24'h123456};
   pix_s        pix;
   int          fails = 0, check_count = 0, cycles = 0, vcount = 0;
   // ********
   // Harness
   // ********
   always #2.5 clock_in = ~clock_in;
   pixel_ctrl_model pixel_ctrl_model_inst (.want_in(want), .pix_out(pix), .latch_clock_out(latch_clock),
      .hsync_n_out(hsync_n));
   pixel_key_out pixel_key_out_inst (.clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_index_in(reg_index_in),
      .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
      .latch_clock_in(latch_clock), .system_blank_n_in(~pix.blank_act), .border_input_in(pix.border),
      .hsync_n_in(hsync_n), .direct_red_in(pix.red), .direct_green_in(pix.green), .direct_blue_in(pix.blue),
      .overlay_in(pix.overlay), .palette_rgb_in(pix.palette), .sense_cmp_in(sense_cmp_in),
      .palette_bypass_in(palette_bypass_in), .border_enable_in(border_enable_in),
      .vga_port_select_in(vga_port_select_in), .packed24_mode_in(packed24_mode_in), .read_mask_in(read_mask_in),
      .palette_page_in(8'h00), .border_rgb_in(border_rgb_in), .dac_ready_in(dac_ready_in),
      .dac_rgb_out(dac_rgb_out), .dac_valid_out(dac_valid_out), .pedestal_out(pedestal_out),
      .pixel_ready_out(pixel_ready_out), .sense_n_out(sense_n_out));
   // Ceiling well above the longest run, which the slowed zoom test bursts dominate
   always @(posedge clock_in) begin
      cycles++;
      if (dac_valid_out === 1'b1) vcount++;
      if (cycles == 60000) begin
         fails++;
         conclude();
      end
   end
   task automatic conclude();
      $display("checks %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [7:0] dat);
      reg_index_in <= idx;
      reg_wdata_in <= dat;
      reg_wr_in <= 1'b1;
      @(posedge clock_in);
      reg_wr_in <= 1'b0;
   endtask
   task automatic rc(input string what, input logic [7:0] idx, input logic [7:0] m, input logic [7:0] exp);
      reg_index_in <= idx;
      reg_rd_in <= 1'b1;
      @(posedge clock_in);
      reg_rd_in <= 1'b0;
      @(negedge clock_in);
      check(what, {16'h0, reg_rdata_out & m}, {16'h0, exp});
      @(posedge clock_in);
   endtask
   task automatic frame(input logic blank, input int n, input int slow);
      want.blank_act = blank;
      pixel_ctrl_model_inst.send(n, slow);
      repeat (16) @(posedge clock_in);
   endtask
   task automatic pc(input string what, input logic [23:0] rgb, input logic ped);
      @(negedge clock_in);
      check(what, dac_rgb_out, rgb);
      check("pedestal", {23'h0, pedestal_out}, {23'h0, ped});
      @(posedge clock_in);
   endtask
   task automatic reg_test();
      logic [7:0] ranges [8] = '{8'h5a, 8'h5a, 8'h40, 8'h40, 8'h00, 8'h7f, 8'hc0, 8'hff};
      for (int i = 0; i < 9; i++) rc("reset value", 8'h30 + 8'(i), 8'hff, 8'h00);
      rc("line select reset", 8'h3e, 8'hff, 8'h00);
      rc("sense disable reset", 8'h3a, 8'h80, 8'h00);
      rc("unmapped", 8'h40, 8'hff, 8'h00);
      for (int i = 0; i < 8; i++) begin
         wr(8'h30 + 8'(i), ranges[i]);
         rc("range register", 8'h30 + 8'(i), 8'hff, ranges[i]);
      end
      wr(8'h38, 8'hb5);
      rc("key control", 8'h38, 8'hff, 8'hb5);
      wr(8'h38, 8'h00);
   endtask
   // Case fields: control, read mask, bypass in bit 1, palette expected in bit 0
   task automatic key_test();
      logic [23:0] cases [9] = '{24'h00ff00, 24'h10ff01, 24'h12ff01, 24'h14ff00, 24'h1aff01,
                                 24'h02ff00, 24'h11ff01, 24'h110f00, 24'h00ff03};
      // Let the closing write of the register test end before the next one
      @(posedge clock_in);
      for (int i = 0; i < 9; i++) begin
         wr(8'h38, cases[i][23:16]);
         read_mask_in <= cases[i][15:8];
         palette_bypass_in <= cases[i][1];
         frame(1'b0, 4, 1);
         pc("keyed pixel", cases[i][0] ? 24'h123456 : 24'h4080c0, 1'b0);
      end
      palette_bypass_in <= 1'b0;
      read_mask_in <= 8'hff;
      wr(8'h38, 8'h00);
   endtask
   // Case fields: border enable, border input, blank, pedestal
   task automatic border_test();
      logic [3:0]  cases [4] = '{4'b1110, 4'b1011, 4'b0111, 4'b1100};
      logic [23:0] exp [4] = '{24'h0a0b0c, 24'h000000, 24'h000000, 24'h4080c0};
      for (int i = 0; i < 4; i++) begin
         border_enable_in <= cases[i][3];
         want.border = cases[i][2];
         frame(cases[i][1], 4, 1);
         pc("border pixel", exp[i], cases[i][0]);
      end
      border_enable_in <= 1'b0;
      want.border = 1'b0;
   endtask
   task automatic zoom_run(input logic [2:0] code, input logic vga, input logic pk, input int slow, output int n);
      wr(8'h38, {code, 5'h00});
      vga_port_select_in <= vga;
      packed24_mode_in <= pk;
      repeat (4) @(posedge clock_in);
      vcount = 0;
      frame(1'b0, 4, slow);
      repeat (100) @(posedge clock_in);
      n = vcount;
   endtask
   // Shown cycles scale with the replication count against an unzoomed burst
   task automatic zoom_test();
      int base;
      int n;
      zoom_run(3'h0, 1'b0, 1'b0, 1, base);
      check("dots at 1x", 24'(base > 0), 24'h1);
      for (int c = 1; c < 6; c++) begin
         zoom_run(3'(c), 1'b0, 1'b0, 1 << c, n);
         check("zoomed dots", 24'(n), 24'(base << c));
      end
      zoom_run(3'h3, 1'b1, 1'b0, 1, n);
      check("vga dots", 24'(n), 24'(base));
      zoom_run(3'h5, 1'b0, 1'b1, 8, n);
      check("packed dots", 24'(n), 24'(base << 3));
      zoom_run(3'h6, 1'b0, 1'b0, 1, n);
      check("unused code dots", 24'(n), 24'(base));
      zoom_run(3'h0, 1'b0, 1'b0, 1, n);
   endtask
   task automatic stall_test();
      dac_ready_in <= 1'b0;
      frame(1'b0, 6, 1);
      @(negedge clock_in);
      check("ready while stalled", {23'h0, pixel_ready_out}, 24'h0);
      check("pixel held", dac_rgb_out, 24'h4080c0);
      @(posedge clock_in);
      dac_ready_in <= 1'b1;
      repeat (40) @(posedge clock_in);
      @(negedge clock_in);
      check("ready after drain", {23'h0, pixel_ready_out}, 24'h1);
      @(posedge clock_in);
   endtask
   task automatic sync_pair();
      pixel_ctrl_model_inst.sync_pair();
      repeat (4) @(posedge clock_in);
   endtask
   task automatic sig_test();
      logic [15:0] crc;
      crc = `SIG_SEED;
      wr(8'h3e, 8'h17);
      rc("line select", 8'h3e, 8'hff, 8'h17);
      wr(8'h3e, 8'h18);
      rc("line select kept", 8'h3e, 8'hff, 8'h17);
      frame(1'b1, 3, 1);
      sync_pair();
      frame(1'b0, 5, 1);
      frame(1'b1, 3, 1);
      sync_pair();
      repeat (5) crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ 1'b1) ? `SIG_POLY : 16'h0000);
      rc("signature low", 8'h3c, 8'hff, crc[7:0]);
      rc("signature high", 8'h3d, 8'hff, crc[15:8]);
   endtask
   task automatic sense_test();
      sense_cmp_in <= 3'b101;
      frame(1'b0, 2, 1);
      frame(1'b1, 2, 1);
      rc("sense register", 8'h3a, 8'hff, 8'h05);
      check("sense pin", {23'h0, sense_n_out}, 24'h0);
      sense_cmp_in <= 3'b010;
      repeat (8) @(posedge clock_in);
      rc("sense latched", 8'h3a, 8'hff, 8'h05);
      wr(8'h3a, 8'h80);
      rc("sense disable", 8'h3a, 8'h80, 8'h80);
      frame(1'b0, 2, 1);
      frame(1'b1, 2, 1);
      rc("sense disabled", 8'h3a, 8'hff, 8'h80);
      check("sense pin off", {23'h0, sense_n_out}, 24'h1);
      wr(8'h3a, 8'h00);
   endtask
   initial begin
      repeat (8) @(posedge clock_in);
      sys_rst_in <= 1'b0;
      repeat (4) @(posedge clock_in);
      reg_test();
      key_test();
      border_test();
      zoom_test();
      stall_test();
      sig_test();
      sense_test();
      conclude();
   end
endmodule // pixel_key_out_tb
`default_nettype wire
